//--- design/nvss_host.sv
// nvss_host: host-side sequencer driving the shadow-sram pins
// assumes the memory answers within one strobe phase of NVSS_CYCLE_CNT cycles
`timescale 1ns/10ps
`default_nettype none
module nvss_host
	import nvss_pkg::*;
#(
	parameter int SAVE_CNT = NVSS_SAVE_CNT,
	parameter int RESTORE_CNT = NVSS_RESTORE_CNT,
	parameter int PWRUP_CNT = NVSS_PWRUP_CNT,
	parameter int CYCLE_CNT = NVSS_CYCLE_CNT
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic reqValid,
	input wire nvss_req_t req,
	output logic reqReady,
	output logic rspValid,
	output logic [NVSS_DW-1:0] rspData,
	output logic busy,
	output nvss_strobe_t strobe,
	output logic [NVSS_AW-1:0] wordSelectLines,
	output logic [NVSS_DW-1:0] sharedByteLinesOut,
	output logic sharedByteLinesOe,
	input wire logic [NVSS_DW-1:0] sharedByteLinesIn
);
	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {NVSS_IDLE, NVSS_SETUP, NVSS_ACTIVE, NVSS_HOLD, NVSS_WAIT} nvss_state_t;
	nvss_state_t state_reg, state_next;
	nvss_req_t cur_reg, cur_next;
	nvss_strobe_t strobe_reg, strobe_next;
	logic [2:0] step_reg, step_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [NVSS_DW-1:0] data_reg, data_next;
	logic oe_reg, oe_next, rdy_reg, rdy_next, rsp_reg, rsp_next, busy_reg, busy_next;
	logic [NVSS_AW-1:0] addr_reg, addr_next;
	logic [NVSS_AW-1:0] seqAddr;
	logic isSeq;

	// one table serves both the next pin address and the check below
	function automatic logic [NVSS_AW-1:0] seqAddrOf(input logic [2:0] s, input nvss_cmd_t c);
		logic [NVSS_AW-1:0] a;
		case (s)
			3'h0: a = NVSS_SEQ0;
			3'h1: a = NVSS_SEQ1;
			3'h2: a = NVSS_SEQ2;
			3'h3: a = NVSS_SEQ3;
			3'h4: a = NVSS_SEQ4;
			3'h5: a = (c == NVSS_CMD_SAVE) ? NVSS_SEQ_SAVE : NVSS_SEQ_RESTORE;
			default: a = NVSS_SEQ0;
		endcase
		return a;
	endfunction

	assign seqAddr = seqAddrOf(step_reg, cur_reg.cmd);

	assign isSeq = (cur_reg.cmd == NVSS_CMD_SAVE) || (cur_reg.cmd == NVSS_CMD_RESTORE);

	always_comb begin
		state_next = state_reg;
		cur_next = cur_reg;
		strobe_next = strobe_reg;
		step_next = step_reg;
		cnt_next = cnt_reg;
		data_next = data_reg;
		addr_next = addr_reg;
		oe_next = oe_reg;
		rdy_next = 1'b0;
		rsp_next = 1'b0;
		busy_next = busy_reg;
		case (state_reg)
			NVSS_IDLE: begin
				if (reqValid) begin
					cur_next = req;
					step_next = 3'h0;
					addr_next = (req.cmd == NVSS_CMD_SAVE || req.cmd == NVSS_CMD_RESTORE) ? NVSS_SEQ0 : req.addr;
					state_next = NVSS_SETUP;
				end else begin
					rdy_next = 1'b1;
				end
			end
			NVSS_SETUP: begin
				// address settles with strobes high; sequence steps never assert write
				strobe_next.chipSel_n = 1'b0;
				strobe_next.writeStrobe_n = !(cur_reg.cmd == NVSS_CMD_WRITE);
				strobe_next.outDrive_n = !(cur_reg.cmd == NVSS_CMD_READ);
				oe_next = (cur_reg.cmd == NVSS_CMD_WRITE);
				cnt_next = 32'(CYCLE_CNT);
				state_next = NVSS_ACTIVE;
			end
			NVSS_ACTIVE: begin
				if (cnt_reg > 32'h1) begin
					cnt_next = cnt_reg - 32'h1;
				end else begin
					// chip select ends every access, so steps are select-clocked
					data_next = sharedByteLinesIn;
					strobe_next.chipSel_n = 1'b1;
					state_next = NVSS_HOLD;
				end
			end
			NVSS_HOLD: begin
				// one cycle of hold keeps address and data past the rising edge
				strobe_next = '{chipSel_n: 1'b1, outDrive_n: 1'b1, writeStrobe_n: 1'b1};
				oe_next = 1'b0;
				if (isSeq && step_reg != NVSS_SEQ_LAST) begin
					step_next = step_reg + 3'h1;
					// address moves only while every strobe is high
					addr_next = seqAddrOf(step_reg + 3'h1, cur_reg.cmd);
					state_next = NVSS_SETUP;
				end else if (isSeq) begin
					step_next = 3'h0;
					busy_next = 1'b1;
					cnt_next = (cur_reg.cmd == NVSS_CMD_SAVE) ? 32'(SAVE_CNT) : 32'(RESTORE_CNT);
					state_next = NVSS_WAIT;
				end else begin
					rsp_next = 1'b1;
					state_next = NVSS_IDLE;
				end
			end
			NVSS_WAIT: begin
				if (cnt_reg > 32'h1) begin
					cnt_next = cnt_reg - 32'h1;
				end else begin
					busy_next = 1'b0;
					rsp_next = 1'b1;
					state_next = NVSS_IDLE;
				end
			end
			default: state_next = NVSS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			// power-up restore window: pins idle with write strobe high
			state_reg <= NVSS_WAIT;
			cnt_reg <= 32'(PWRUP_CNT);
			busy_reg <= 1'b1;
			cur_reg <= '0;
			strobe_reg <= '{chipSel_n: 1'b1, outDrive_n: 1'b1, writeStrobe_n: 1'b1};
			step_reg <= 3'h0;
			data_reg <= '0;
			addr_reg <= '0;
			oe_reg <= 1'b0;
			rdy_reg <= 1'b0;
			rsp_reg <= 1'b0;
		end else if (clkEn) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			cur_reg <= cur_next;
			strobe_reg <= strobe_next;
			step_reg <= step_next;
			data_reg <= data_next;
			addr_reg <= addr_next;
			oe_reg <= oe_next;
			rdy_reg <= rdy_next;
			rsp_reg <= rsp_next;
		end
	end

	// pins come straight from registers, so no decode glitch reaches the memory
	assign reqReady = rdy_reg;
	assign rspValid = rsp_reg;
	assign rspData = data_reg;
	assign busy = busy_reg;
	assign strobe = strobe_reg;
	assign wordSelectLines = addr_reg;
	assign sharedByteLinesOut = cur_reg.data;
	assign sharedByteLinesOe = oe_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_write_no_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
		!strobe_reg.writeStrobe_n |-> strobe_reg.outDrive_n && oe_reg)
		else $error("output drive low during write");
	a_seq_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(isSeq && state_reg != NVSS_IDLE) |-> strobe_reg.writeStrobe_n)
		else $error("write strobe low in sequence");
	a_addr_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!strobe_reg.chipSel_n && clkEn && $past(!strobe_reg.chipSel_n)) |-> $stable(addr_reg))
		else $error("address moved during access");
	a_select_ends: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == NVSS_HOLD && clkEn) |-> strobe_reg.chipSel_n)
		else $error("access not ended by chip select");
	a_seq_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		(isSeq && state_reg == NVSS_ACTIVE) |-> addr_reg == seqAddr)
		else $error("wrong sequence address");
	a_busy_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == NVSS_WAIT) |-> busy_reg && strobe_reg.chipSel_n)
		else $error("access during nonvolatile wait");
	a_step_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == NVSS_WAIT) |-> step_reg == 3'h0)
		else $error("step not reset after sequence");
	a_read_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cur_reg.cmd == NVSS_CMD_READ && !strobe_reg.chipSel_n) |-> !strobe_reg.outDrive_n && !oe_reg)
		else $error("read strobes wrong");
endmodule
`default_nettype wire

//--- design/nvss_pkg.sv
// nvss_pkg: constants and carrier types for the shadow-sram host controller
// assumes a 125 MHz core clock and the async byte-wide memory on the pins
`default_nettype none
package nvss_pkg;
	localparam int NVSS_AW = 11;
	localparam int NVSS_DW = 8;
	localparam int NVSS_CLK_MHZ = 125;
	// access time in ns, durations in us; cycle counts derived from the clock
	localparam int NVSS_CYCLE_NS = 50;
	localparam int NVSS_CYCLE_CNT = (NVSS_CYCLE_NS * NVSS_CLK_MHZ + 999) / 1000;
	localparam int NVSS_SAVE_US = 10000;
	localparam int NVSS_RESTORE_US = 20;
	localparam int NVSS_PWRUP_US = 550;
	localparam int NVSS_SAVE_CNT = NVSS_SAVE_US * NVSS_CLK_MHZ;
	localparam int NVSS_RESTORE_CNT = NVSS_RESTORE_US * NVSS_CLK_MHZ;
	localparam int NVSS_PWRUP_CNT = NVSS_PWRUP_US * NVSS_CLK_MHZ;
	localparam logic [10:0] NVSS_SEQ0 = 11'h000;
	localparam logic [10:0] NVSS_SEQ1 = 11'h555;
	localparam logic [10:0] NVSS_SEQ2 = 11'h2aa;
	localparam logic [10:0] NVSS_SEQ3 = 11'h7ff;
	localparam logic [10:0] NVSS_SEQ4 = 11'h0f0;
	localparam logic [10:0] NVSS_SEQ_SAVE = 11'h70f;
	localparam logic [10:0] NVSS_SEQ_RESTORE = 11'h70e;
	localparam logic [2:0] NVSS_SEQ_LAST = 3'h5;
	typedef enum logic [1:0] {NVSS_CMD_READ, NVSS_CMD_WRITE, NVSS_CMD_SAVE, NVSS_CMD_RESTORE} nvss_cmd_t;
	typedef struct packed {
		nvss_cmd_t cmd;
		logic [10:0] addr;
		logic [7:0] data;
	} nvss_req_t;
	typedef struct packed {
		logic chipSel_n;
		logic outDrive_n;
		logic writeStrobe_n;
	} nvss_strobe_t;
endpackage
`default_nettype wire

//--- dv/nvss_host_test.sv
// nvss_host_test: directed bench for the shadow-sram host sequencer
// assumes nvss_mem_model on the pins and shortened save/restore counts
`timescale 1ns/10ps
`default_nettype none
module nvss_host_test
	import nvss_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reqValid = 1'b0;
	logic supplyLow = 1'b0;
	logic clkEn = 1'b1;
	localparam int REST_CYC = 10;
	nvss_req_t req = '0;
	logic reqReady, rspValid, busy, sharedByteLinesOe, sawBusy;
	logic [7:0] rspData, sharedByteLinesOut, devOut, busLevel;
	logic [10:0] wordSelectLines;
	nvss_strobe_t strobe;
	int num_errors = 0;
	int cmp_count = 0;
	assign busLevel = sharedByteLinesOe ? sharedByteLinesOut : devOut;
	nvss_host #(.SAVE_CNT(20), .RESTORE_CNT(REST_CYC), .PWRUP_CNT(10), .CYCLE_CNT(2)) i_nvss_host(.core_clk(core_clk),
		.rst_n(rst_n), .clkEn(clkEn), .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
		.rspData(rspData), .busy(busy), .strobe(strobe), .wordSelectLines(wordSelectLines),
		.sharedByteLinesOut(sharedByteLinesOut), .sharedByteLinesOe(sharedByteLinesOe), .sharedByteLinesIn(busLevel));
	nvss_mem_model i_nvss_mem_model(.clk(core_clk), .supplyLow(supplyLow), .strobe(strobe),
		.addr(wordSelectLines), .busIn(busLevel), .busOut(devOut));
	initial forever #4 core_clk = ~core_clk;
	task automatic end_sim();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one request, waits bounded for the answer pulse
	task automatic op(input nvss_cmd_t c, input logic [10:0] a, input logic [7:0] d);
		int n;
		n = 0;
		sawBusy = 1'b0;
		while (reqReady !== 1'b1 && n < 500) begin
			@(posedge core_clk);
			n++;
		end
		req <= '{cmd: c, addr: a, data: d};
		reqValid <= 1'b1;
		@(posedge core_clk);
		reqValid <= 1'b0;
		do begin
			@(posedge core_clk);
			n++;
			if (busy === 1'b1) sawBusy = 1'b1;
		end while (rspValid !== 1'b1 && n < 500);
		if (n >= 500) begin
			num_errors++;
			end_sim();
		end
	endtask
	task automatic t_rw();
		logic [10:0] al [4] = '{11'h000, 11'h7ff, 11'h555, 11'h2aa};
		foreach (al[i]) op(NVSS_CMD_WRITE, al[i], 8'(8'h11 * (i + 1)));
		foreach (al[i]) begin
			op(NVSS_CMD_READ, al[i], 8'h00);
			chk("read back", rspData, 8'(8'h11 * (i + 1)));
		end
	endtask
	task automatic t_save_restore();
		op(NVSS_CMD_WRITE, 11'h123, 8'ha5);
		op(NVSS_CMD_SAVE, 11'h000, 8'h00);
		chk("busy in save", {7'h00, sawBusy}, 8'h01);
		op(NVSS_CMD_WRITE, 11'h123, 8'h5a);
		op(NVSS_CMD_READ, 11'h123, 8'h00);
		chk("after save", rspData, 8'h5a);
		op(NVSS_CMD_RESTORE, 11'h000, 8'h00);
		chk("busy in restore", {7'h00, sawBusy}, 8'h01);
		op(NVSS_CMD_READ, 11'h123, 8'h00);
		chk("restored", rspData, 8'ha5);
	endtask
	// a write between steps must void the sequence, a clean run of reads must not
	task automatic t_abort();
		logic [10:0] sq [6] = '{11'h000, 11'h555, 11'h2aa, 11'h7ff, 11'h0f0, 11'h70e};
		foreach (sq[i]) begin
			if (i == 3) op(NVSS_CMD_WRITE, 11'h123, 8'h3c);
			op(NVSS_CMD_READ, sq[i], 8'h00);
		end
		op(NVSS_CMD_READ, 11'h123, 8'h00);
		chk("aborted", rspData, 8'h3c);
		foreach (sq[i]) op(NVSS_CMD_READ, sq[i], 8'h00);
		// plain reads launched a restore; the memory is shut until it ends
		repeat (REST_CYC) @(posedge core_clk);
		op(NVSS_CMD_READ, 11'h123, 8'h00);
		chk("read sequence", rspData, 8'ha5);
	endtask
	task automatic t_low_supply();
		supplyLow <= 1'b1;
		op(NVSS_CMD_WRITE, 11'h123, 8'h77);
		op(NVSS_CMD_SAVE, 11'h000, 8'h00);
		supplyLow <= 1'b0;
		op(NVSS_CMD_RESTORE, 11'h000, 8'h00);
		op(NVSS_CMD_READ, 11'h123, 8'h00);
		chk("save refused", rspData, 8'ha5);
	endtask
	// a request offered while the clock enable is low must not be taken
	task automatic t_freeze();
		repeat (2) @(posedge core_clk);
		clkEn <= 1'b0;
		req <= '{cmd: NVSS_CMD_WRITE, addr: 11'h123, data: 8'h99};
		reqValid <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk("frozen strobes", {5'h00, strobe}, 8'h07);
		chk("frozen ready", {7'h00, reqReady}, 8'h01);
		clkEn <= 1'b1;
		reqValid <= 1'b0;
		@(posedge core_clk);
	endtask
	// mid-run reset: power-up wait again, memory contents survive
	task automatic t_reset();
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("reset busy", {5'h00, busy, strobe.chipSel_n, strobe.writeStrobe_n}, 8'h07);
		rst_n <= 1'b1;
		op(NVSS_CMD_READ, 11'h123, 8'h00);
		chk("after reset", rspData, 8'ha5);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		chk("reset strobes", {5'h00, strobe}, 8'h07);
		chk("reset oe busy", {6'h00, sharedByteLinesOe, busy}, 8'h01);
		rst_n <= 1'b1;
		t_rw();
		t_freeze();
		t_save_restore();
		t_abort();
		t_low_supply();
		t_reset();
		end_sim();
	end
endmodule
`default_nettype wire

//--- dv/nvss_mem_model.sv
// nvss_mem_model: behavioural shadow-sram device facing the host sequencer
// assumes strobes change on clk edges and write data is held until strobes rise
`timescale 1ns/10ps
`default_nettype none
module nvss_mem_model
	import nvss_pkg::*;
#(parameter int HOLD_SAVE = 16, parameter int HOLD_REST = 8) (
	input wire logic clk,
	input wire logic supplyLow,
	input wire nvss_strobe_t strobe,
	input wire logic [10:0] addr,
	input wire logic [7:0] busIn,
	output logic [7:0] busOut
);
	logic [7:0] sram [2048];
	logic [7:0] shadow [2048];
	logic [10:0] seqTab [5] = '{NVSS_SEQ0, NVSS_SEQ1, NVSS_SEQ2, NVSS_SEQ3, NVSS_SEQ4};
	nvss_strobe_t prevStb = 3'h7;
	logic [10:0] prevAddr = 11'h000;
	logic [7:0] prevBus = 8'h00;
	logic [7:0] lastOut = 8'h00;
	int step = 0;
	int holdOff = HOLD_REST;
	wire logic rdOn = !strobe.chipSel_n && !strobe.outDrive_n && strobe.writeStrobe_n && holdOff == 0;
	wire logic accEnd = !prevStb.chipSel_n && (strobe.chipSel_n || (!prevStb.writeStrobe_n && strobe.writeStrobe_n));
	// released bus shows the inverse of the last byte, never a stale copy
	assign busOut = rdOn ? sram[addr] : ~lastOut;
	initial foreach (sram[i]) begin
		shadow[i] = 8'h00;
		sram[i] = 8'h00;
	end
	always @(posedge clk) begin
		prevStb <= strobe;
		prevAddr <= addr;
		prevBus <= busIn;
		if (rdOn)
			lastOut <= sram[addr];
		if (holdOff > 0)
			holdOff <= holdOff - 1;
		else if (accEnd && !prevStb.writeStrobe_n) begin
			sram[prevAddr] <= prevBus;
			step <= 0;
		end else if (accEnd && step == 5) begin
			step <= 0;
			if (prevAddr == NVSS_SEQ_RESTORE) begin
				foreach (sram[i]) sram[i] <= shadow[i];
				holdOff <= HOLD_REST;
			end else if (prevAddr == NVSS_SEQ_SAVE && !supplyLow) begin
				foreach (shadow[i]) shadow[i] <= sram[i];
				holdOff <= HOLD_SAVE;
			end
		end else if (accEnd)
			step <= (prevAddr == seqTab[step]) ? step + 1 : 0;
	end
endmodule
`default_nettype wire
